//--- core/pspc_pkg.sv
package pspc_pkg;
   // ----------------------------------------
   // Mode strap codes (bit2, bit1, bit0)
   // ----------------------------------------
   localparam logic [2:0] PSPC_MODE_BRIDGE_DUAL = 3'h0;
   localparam logic [2:0] PSPC_MODE_BRIDGE_NOOVL = 3'h1;
   localparam logic [2:0] PSPC_MODE_BRIDGE_SINGLE = 3'h2;
   localparam logic [2:0] PSPC_MODE_PARALLEL = 3'h3;
   localparam logic [2:0] PSPC_MODE_SINGLE_FULL = 3'h4;
   localparam logic [2:0] PSPC_MODE_SINGLE_NOOVL = 3'h5;
   // ----------------------------------------
   // Half-bridge vector positions
   // ----------------------------------------
   localparam int PSPC_HB_A = 0;
   localparam int PSPC_HB_B = 1;
   localparam int PSPC_HB_C = 2;
   localparam int PSPC_HB_D = 3;
   localparam int PSPC_NUM_HB = 4;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int PSPC_CLK_MHZ = 100;
   localparam int PSPC_STRAP_SETTLE = 2;
   localparam logic [3:0] PSPC_RESET_VAL = 4'h0;
   typedef enum logic [3:0] {
      PSPC_ST_STRAP = 4'h1,
      PSPC_ST_CHECK = 4'h2,
      PSPC_ST_RUN = 4'h4,
      PSPC_ST_HALT = 4'h8
   } pspc_state_t;
endpackage

//--- core/pspc_sync_if.sv
`timescale 1ns/1ps
interface pspc_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport syncer (input raw, output synced);
   modport user (output raw, input synced);
endinterface

//--- core/pspc_sync.sv
`timescale 1ns/1ps
module pspc_sync
   import pspc_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   pspc_sync_if.syncer port
);
   // ----------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= port.raw;
         stage2 <= stage1;
      end
   end
   assign port.synced = stage2;
endmodule

//--- core/pspc_top.sv
`timescale 1ns/1ps
// What this block does
// - During the pin short check hold shutdown low; pair resets only switch the weak pulldowns.
// - A check that finds no short passes and releases the shutdown flag.
// - Pair resets never restart the short check; it runs once per start-up.
// - Run the short check in bridged and parallel modes, skip it single-ended.
// - Warning flag low while the warning comparator reports overheating.
// - Overtemperature trip puts all outputs Hi-Z, shutdown low, latches error.
// - Only a pair reset assertion or power-on reset clears the latched overtemperature error.
// - Power-on reset clears overload state before operation starts.
// - Undervoltage forces Hi-Z and shutdown low; recovery is automatic.
// - Both flags are active-low open-drain outputs with pull-ups.
// - Any shutting fault pulls shutdown low; warning reported independently.
// - Once running, any pair reset low releases the shutdown flag regardless of faults.
// - A pair reset low puts that pair's half-bridges in Hi-Z.
// - Bridged modes enable weak pulldowns on a reset pair; single-ended never.
// - A rising pair reset edge clears latched overload and resumes switching.
// - Straps decode into bridged, parallel, single-ended modes or reserved.
// - Parallel mode uses PWM D to choose single-line or dual-line input.
// - Overload shutdown latches per pair, A/B and C/D; a rising edge on either pair reset clears both.
// - Other faults, except the latched overtemperature error, clear by themselves once the condition disappears.
module pspc_top
   import pspc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic mode_strap_bit0,
   input wire logic mode_strap_bit1,
   input wire logic mode_strap_bit2,
   input wire logic pair_ab_reset_n,
   input wire logic pair_cd_reset_n,
   input wire logic temp_warn_trip,
   input wire logic temp_error_trip,
   input wire logic undervoltage_guard,
   input wire logic overload_ab,
   input wire logic overload_cd,
   input wire logic short_found,
   input wire logic short_check_done,
   input wire logic pwm_d_in,
   input wire logic shutdown_flag_n_in,
   output logic shutdown_flag_n_out,
   output logic shutdown_flag_n_oe,
   input wire logic temp_warning_n_in,
   output logic temp_warning_n_out,
   output logic temp_warning_n_oe,
   output logic pin_short_check,
   output logic short_check_start,
   output logic [3:0] hb_enable,
   output logic [3:0] weak_pulldown_en,
   output logic pwm_d_pulldown_en,
   output logic dual_line_input,
   output logic single_line_input,
   output logic bridged_mode,
   output logic parallel_bridged_mode,
   output logic single_ended_mode,
   output logic overload_enable,
   output logic overtemp_error_latch,
   output logic [1:0] overload_shutdown,
   output logic mode_reserved
);
   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   localparam int SW = 13;
   pspc_sync_if #(.W(SW)) sif ();
   assign sif.raw = {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0,
                     pair_ab_reset_n, pair_cd_reset_n, temp_warn_trip,
                     temp_error_trip, undervoltage_guard, overload_ab,
                     overload_cd, short_found, short_check_done, pwm_d_in};
   pspc_sync #(.W(SW)) pspc_sync_inst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port(sif.syncer)
   );
   logic [2:0] strap_s;
   logic rab_s, rcd_s, twarn_s, terr_s, uv_s, ol_ab_s, ol_cd_s;
   logic short_s, done_s, pwmd_s;
   assign strap_s = sif.synced[12:10];
   assign rab_s = sif.synced[9];
   assign rcd_s = sif.synced[8];
   assign twarn_s = sif.synced[7];
   assign terr_s = sif.synced[6];
   assign uv_s = sif.synced[5];
   assign ol_ab_s = sif.synced[4];
   assign ol_cd_s = sif.synced[3];
   assign short_s = sif.synced[2];
   assign done_s = sif.synced[1];
   assign pwmd_s = sif.synced[0];

   // ----------------------------------------
   // Start-up sequence
   // ----------------------------------------
   // Straps are static; a settle count lets the synchronisers fill first.
   pspc_state_t state;
   logic [1:0] settle;
   logic [2:0] mode;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PSPC_ST_STRAP;
         settle <= '0;
         mode <= 3'h0;
      end else begin
         case (state)
            PSPC_ST_STRAP: begin
               settle <= settle + 2'h1;
               if (settle == 2'(PSPC_STRAP_SETTLE)) begin
                  mode <= strap_s;
                  if (strap_s[2:1] == 2'h3) begin
                     state <= PSPC_ST_HALT;
                  end else if (strap_s[2]) begin
                     state <= PSPC_ST_RUN;
                  end else begin
                     state <= PSPC_ST_CHECK;
                  end
               end
            end
            PSPC_ST_CHECK: begin
               if (done_s && !short_s) begin
                  state <= PSPC_ST_RUN;
               end
            end
            PSPC_ST_RUN: begin
               state <= PSPC_ST_RUN;
            end
            PSPC_ST_HALT: begin
               state <= PSPC_ST_HALT;
            end
            default: begin
               state <= PSPC_ST_STRAP;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   logic running, checking;
   assign running = (state == PSPC_ST_RUN);
   assign checking = (state == PSPC_ST_CHECK);
   always_comb begin
      bridged_mode = 1'b0;
      parallel_bridged_mode = 1'b0;
      single_ended_mode = 1'b0;
      overload_enable = 1'b1;
      mode_reserved = 1'b0;
      case (mode)
         PSPC_MODE_BRIDGE_DUAL: bridged_mode = 1'b1;
         PSPC_MODE_BRIDGE_NOOVL: begin
            bridged_mode = 1'b1;
            overload_enable = 1'b0;
         end
         PSPC_MODE_BRIDGE_SINGLE: bridged_mode = 1'b1;
         PSPC_MODE_PARALLEL: parallel_bridged_mode = 1'b1;
         PSPC_MODE_SINGLE_FULL: single_ended_mode = 1'b1;
         PSPC_MODE_SINGLE_NOOVL: begin
            single_ended_mode = 1'b1;
            overload_enable = 1'b0;
         end
         default: begin
            mode_reserved = 1'b1;
            overload_enable = 1'b0;
         end
      endcase
      if (state == PSPC_ST_STRAP || state == PSPC_ST_HALT) begin
         mode_reserved = (state == PSPC_ST_HALT);
      end
   end
   assign pwm_d_pulldown_en = parallel_bridged_mode;
   always_comb begin
      dual_line_input = 1'b0;
      single_line_input = 1'b0;
      if (parallel_bridged_mode) begin
         dual_line_input = pwmd_s;
         single_line_input = !pwmd_s;
      end else if (mode == PSPC_MODE_BRIDGE_DUAL || mode == PSPC_MODE_BRIDGE_NOOVL) begin
         dual_line_input = 1'b1;
      end else if (!mode_reserved) begin
         single_line_input = 1'b1;
      end
   end

   // ----------------------------------------
   // Pair reset edges
   // ----------------------------------------
   // Reset inputs are gated out while the short check runs.
   logic rab_q, rcd_q, rab_rise, rcd_rise, any_reset_low;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rab_q <= 1'b1;
         rcd_q <= 1'b1;
      end else begin
         rab_q <= rab_s;
         rcd_q <= rcd_s;
      end
   end
   assign rab_rise = running && rab_s && !rab_q;
   assign rcd_rise = running && rcd_s && !rcd_q;
   assign any_reset_low = running && (!rab_s || !rcd_s);

   // ----------------------------------------
   // Fault latches
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overtemp_error_latch <= 1'b0;
      end else if (running && terr_s) begin
         overtemp_error_latch <= 1'b1;
      end else if (any_reset_low) begin
         overtemp_error_latch <= 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overload_shutdown <= 2'h0;
      end else begin
         if (running && overload_enable && ol_ab_s) begin
            overload_shutdown[0] <= 1'b1;
         end else if (rab_rise || rcd_rise) begin
            overload_shutdown[0] <= 1'b0;
         end
         if (running && overload_enable && ol_cd_s) begin
            overload_shutdown[1] <= 1'b1;
         end else if (rab_rise || rcd_rise) begin
            overload_shutdown[1] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Output stage control
   // ----------------------------------------
   logic global_off, shut_fault, next_shdn_oe;
   assign global_off = !running || uv_s || overtemp_error_latch;
   assign shut_fault = uv_s || overtemp_error_latch || (|overload_shutdown);
   genvar g;
   generate
      for (g = 0; g < PSPC_NUM_HB; g++) begin : g_hb
         localparam int P = g / 2;
         logic pair_rst;
         assign pair_rst = (P == 0) ? !rab_s : !rcd_s;
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               hb_enable[g] <= 1'b0;
               weak_pulldown_en[g] <= 1'b0;
            end else begin
               hb_enable[g] <= !global_off && !overload_shutdown[P] && !pair_rst;
               weak_pulldown_en[g] <= pair_rst && !single_ended_mode
                  && !mode_reserved && state != PSPC_ST_STRAP;
            end
         end
      end
   endgenerate
   // Reset low forces the flag released only in run; the check, strap and halt states hold it.
   assign next_shdn_oe = checking || (running && shut_fault && !any_reset_low)
                        || state == PSPC_ST_STRAP || state == PSPC_ST_HALT;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_flag_n_oe <= 1'b1;
         temp_warning_n_oe <= 1'b0;
      end else begin
         shutdown_flag_n_oe <= next_shdn_oe;
         temp_warning_n_oe <= twarn_s;
      end
   end
   assign shutdown_flag_n_out = 1'b0;
   assign temp_warning_n_out = 1'b0;
   assign pin_short_check = checking;
   assign short_check_start = checking;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_trip;
      running && terr_s;
   endsequence
   sequence s_latched;
      overtemp_error_latch ##1 !hb_enable[0] && !hb_enable[3];
   endsequence
   AST_CHECK_SHDN: assert property (@(posedge core_clk) disable iff (!rst_n)
      checking |=> shutdown_flag_n_oe)
      else $error("shutdown not held during short check");
   AST_PASS: assert property (@(posedge core_clk) disable iff (!rst_n)
      checking && done_s && !short_s |=> running)
      else $error("check pass not taken");
   AST_NO_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
      running |=> running)
      else $error("short check restarted");
   AST_WARN: assert property (@(posedge core_clk) disable iff (!rst_n)
      twarn_s |=> temp_warning_n_oe)
      else $error("warning flag not driven");
   AST_OVERTEMP: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_trip |=> s_latched)
      else $error("overtemp trip not acted on");
   AST_UV: assert property (@(posedge core_clk) disable iff (!rst_n)
      uv_s |=> hb_enable == 4'h0)
      else $error("undervoltage left outputs on");
   AST_RST_SHDN: assert property (@(posedge core_clk) disable iff (!rst_n)
      running && !rab_s |=> !shutdown_flag_n_oe)
      else $error("reset did not release shutdown");
   AST_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
      !rcd_s |=> hb_enable[2] == 1'b0 && hb_enable[3] == 1'b0)
      else $error("pair reset left cd on");
   AST_SINGLE_PD: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_ended_mode |=> weak_pulldown_en == 4'h0)
      else $error("pulldown in single-ended");
endmodule

//--- testbench/pspc_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// System controller on the far side of the flags and pair resets
// ----------------------------------------
module pspc_ctrl_model #(
   parameter int RECOVER_CYC = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ab_req_n,
   input wire logic cd_req_n,
   input wire logic shdn_oe,
   input wire logic shdn_out,
   input wire logic tw_oe,
   input wire logic tw_out,
   input wire logic single_ended,
   output logic pair_ab_reset_n,
   output logic pair_cd_reset_n,
   output logic shdn_wire,
   output logic tw_wire,
   output logic pwm_low_n
);
   logic [7:0] since_low;
   logic [1:0] rst_q;
   logic [1:0] rose;
   // Pull-ups hold each flag high whenever the device lets go.
   assign shdn_wire = shdn_oe ? shdn_out : 1'b1;
   assign tw_wire = tw_oe ? tw_out : 1'b1;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         since_low <= 8'h0;
      end else if (!shdn_wire) begin
         since_low <= 8'h0;
      end else if (since_low != 8'hff) begin
         since_low <= since_low + 8'h1;
      end
   end
   // The recovery wait is cut from milliseconds to a few cycles to keep runs short.
   // Counting from the last low cycle is stricter than from the fall, which is safe.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pair_ab_reset_n <= 1'b0;
         pair_cd_reset_n <= 1'b0;
      end else begin
         if (!ab_req_n) begin
            pair_ab_reset_n <= 1'b0;
         end else if (since_low >= 8'(RECOVER_CYC)) begin
            pair_ab_reset_n <= 1'b1;
         end
         if (!cd_req_n) begin
            pair_cd_reset_n <= 1'b0;
         end else if (since_low >= 8'(RECOVER_CYC)) begin
            pair_cd_reset_n <= 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {pair_cd_reset_n, pair_ab_reset_n};
      end
   end
   // A one-cycle low on PWM at release charges the bootstrap capacitors when single-ended.
   assign rose = {pair_cd_reset_n, pair_ab_reset_n} & ~rst_q;
   assign pwm_low_n = !(single_ended && (|rose));
endmodule

//--- testbench/test_power_stage_protection_ctrl.sv
`timescale 1ns/1ps
module test_power_stage_protection_ctrl import pspc_pkg::*;;
   logic core_clk, rst_n, pwm_d_in, ab_req_n, cd_req_n;
   logic [2:0] strap;
   logic [6:0] cond;
   logic shdn_oe, shdn_out, tw_oe, tw_out, shdn_wire, tw_wire, pair_ab_reset_n, pair_cd_reset_n;
   logic pin_short_check, short_check_start, pwm_low_n, pwm_d_pulldown_en;
   logic dual_line_input, single_line_input;
   logic bridged_mode, parallel_bridged_mode, single_ended_mode, overload_enable;
   logic otel, mode_reserved;
   logic [3:0] hb_enable, weak_pulldown_en;
   logic [1:0] overload_shutdown;
   logic [7:0] exp_mode;
   int fails, samples_checked;
   pspc_top pspc_top_inst (
      .core_clk, .rst_n, .mode_strap_bit0(strap[0]), .mode_strap_bit1(strap[1]),
      .mode_strap_bit2(strap[2]), .pair_ab_reset_n, .pair_cd_reset_n,
      .temp_warn_trip(cond[0]), .temp_error_trip(cond[1]), .undervoltage_guard(cond[2]),
      .overload_ab(cond[3]), .overload_cd(cond[4]), .short_found(cond[5]),
      .short_check_done(cond[6]), .pwm_d_in(pwm_d_in && pwm_low_n),
      .shutdown_flag_n_in(shdn_wire), .shutdown_flag_n_out(shdn_out),
      .shutdown_flag_n_oe(shdn_oe), .temp_warning_n_in(tw_wire),
      .temp_warning_n_out(tw_out), .temp_warning_n_oe(tw_oe), .pin_short_check,
      .short_check_start, .hb_enable, .weak_pulldown_en, .pwm_d_pulldown_en,
      .dual_line_input, .single_line_input, .bridged_mode, .parallel_bridged_mode,
      .single_ended_mode, .overload_enable, .overtemp_error_latch(otel),
      .overload_shutdown, .mode_reserved
   );
   pspc_ctrl_model pspc_ctrl_model_inst (
      .core_clk, .rst_n, .ab_req_n, .cd_req_n, .shdn_oe, .shdn_out, .tw_oe, .tw_out,
      .single_ended(single_ended_mode), .pair_ab_reset_n, .pair_cd_reset_n, .shdn_wire,
      .tw_wire, .pwm_low_n
   );
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Drive conditions and reset requests, then wait past the sync and recovery delays.
   task automatic apply(input logic [6:0] c, input logic [1:0] rq);
      @(posedge core_clk);
      cond <= c;
      ab_req_n <= rq[0];
      cd_req_n <= rq[1];
      repeat (24) @(posedge core_clk);
      #1;
   endtask
   // Straps are only sampled after reset, so every mode change needs a fresh start-up.
   task automatic power_up(input logic [2:0] m);
      @(posedge core_clk);
      rst_n <= 1'b0;
      strap <= m;
      ab_req_n <= 1'b0;
      cd_req_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      apply(cond, 2'h0);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      close_out();
   end
   initial begin
      rst_n = 1'b0;
      pwm_d_in = 1'b1;
      ab_req_n = 1'b0;
      cd_req_n = 1'b0;
      strap = 3'h0;
      cond = 7'h0;
      fails = 0;
      samples_checked = 0;
      power_up(PSPC_MODE_SINGLE_FULL);
      chk(8'(pin_short_check), 8'h0);
      chk(8'(weak_pulldown_en), 8'h0);
      chk(8'(hb_enable), 8'h0);
      chk(8'(shdn_wire), 8'h1);
      apply(7'h00, 2'h3);
      chk(8'({hb_enable, shdn_wire, tw_wire}), 8'h3f);
      apply(7'h01, 2'h3);
      chk(8'({shdn_wire, tw_wire}), 8'h2);
      apply(7'h02, 2'h3);
      chk(8'({hb_enable, shdn_wire, tw_wire, otel}), 8'h03);
      apply(7'h00, 2'h3);
      chk(8'({hb_enable, otel}), 8'h01);
      apply(7'h00, 2'h2);
      chk(8'({hb_enable, shdn_wire, otel}), 8'h32);
      apply(7'h00, 2'h3);
      chk(8'(hb_enable), 8'hf);
      apply(7'h04, 2'h3);
      chk(8'({hb_enable, shdn_wire}), 8'h0);
      apply(7'h00, 2'h3);
      chk(8'({hb_enable, shdn_wire}), 8'h1f);
      apply(7'h08, 2'h3);
      chk(8'({hb_enable, overload_shutdown, shdn_wire}), 8'h62);
      apply(7'h00, 2'h3);
      chk(8'({hb_enable, overload_shutdown}), 8'h31);
      apply(7'h00, 2'h1);
      chk(8'(shdn_wire), 8'h1);
      apply(7'h00, 2'h3);
      chk(8'({hb_enable, overload_shutdown}), 8'h3c);
      apply(7'h10, 2'h3);
      chk(8'({hb_enable, overload_shutdown}), 8'h0e);
      power_up(PSPC_MODE_BRIDGE_DUAL);
      chk(8'(overload_shutdown), 8'h0);
      chk(8'({pin_short_check, short_check_start, shdn_wire}), 8'h6);
      apply(7'h60, 2'h3);
      chk(8'({pin_short_check, shdn_wire, hb_enable}), 8'h20);
      apply(7'h40, 2'h3);
      chk(8'({pin_short_check, shdn_wire, hb_enable}), 8'h1f);
      apply(7'h40, 2'h2);
      chk(8'({pin_short_check, short_check_start}), 8'h0);
      chk(8'({hb_enable, weak_pulldown_en}), 8'hc3);
      for (int m = 0; m < 8; m++) begin
         power_up(3'(m));
         exp_mode = {m <= 2, m == 3, m == 4 || m == 5, m != 1 && m < 5, 1'b0,
            m <= 1 || m == 3, m == 2 || m == 4 || m == 5, m == 3};
         if (m < 6) begin
            chk({bridged_mode, parallel_bridged_mode, single_ended_mode, overload_enable,
               mode_reserved, dual_line_input, single_line_input, pwm_d_pulldown_en},
               exp_mode);
         end
         apply(7'h40, 2'h3);
         chk(8'({mode_reserved, hb_enable}), (m >= 6) ? 8'h10 : 8'h0f);
         if (m == 1 || m == 5) begin
            apply(7'h48, 2'h3);
            chk(8'(hb_enable), 8'hf);
         end
      end
      power_up(PSPC_MODE_PARALLEL);
      @(posedge core_clk);
      pwm_d_in <= 1'b0;
      apply(7'h40, 2'h3);
      chk(8'({dual_line_input, single_line_input}), 8'h1);
      close_out();
   end
endmodule
